// ===== ccc_pkg.sv
package ccc_pkg;
   localparam int CCC_CHANNELS = 2;
   localparam int CCC_POINTS = 2;
   localparam int CCC_SOURCES = 4;
   localparam int CCC_COUNT_WIDTH = 32;
   localparam int CCC_IRQ_NUM_WIDTH = 8;
   localparam int CCC_CLK_MHZ = 250;
   localparam int CCC_IRQ_LATENCY_US = 150;
   localparam int CCC_IRQ_LATENCY_CYCLES = CCC_IRQ_LATENCY_US * CCC_CLK_MHZ;
   localparam logic [CCC_IRQ_NUM_WIDTH-1:0] CCC_IRQ_NUM_RESET = 8'h00;
   localparam logic CCC_FLAG_RESET = 1'b0;
endpackage

// ===== ccc_compare.sv
// Operation
// (R1) Match flag sets when count equals point
// (R2) Flags set regardless of output enable
// (R3) Greater/less may overlap match briefly
// (R4) Output pulses only on flag rising edge; the code holds the pin high while the flag and channel enable stay set
// (R5) Program holds clear command at least 2ms
// (R6) Clear command releases latched match flag
// (R7) Per-channel option: preset on point-1 match
// (R8) Point 2 never triggers preset
// (R9) Preset loads count on point-1 rising edge
// (R10) Newest preset value is always loaded
// (R11) No reload while flag stays set
// (R12) Z-phase request flag blocks preset replacement
// (R13) Program spaces preset write by 2ms
// (R14) Four sources: ch1 p1,p2, ch2 p1,p2
// (R15) Interrupt numbers set by configuration
// (R16) Per-point use setting gates interrupt
// (R17) Per-source mask gates interrupt
// (R18) Interrupt follows match after about 150us
// (R19) Interrupt only on flag rising edge
// (R20) Channel enable gates both point outputs
// (R21) Greater and less flags track comparison
// (R22) Clear released during match sets again
// (R23) Compare each update, register edge pulse
`timescale 1ns/1ps
`default_nettype none
module ccc_compare
   import ccc_pkg::*;
#(
   parameter int COUNT_WIDTH = CCC_COUNT_WIDTH,
   parameter int IRQ_LATENCY_CYCLES = CCC_IRQ_LATENCY_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Counter side, index = channel
   input wire logic [COUNT_WIDTH-1:0] count_value [CCC_CHANNELS],
   input wire logic [COUNT_WIDTH-1:0] cmp1_point [CCC_CHANNELS],
   input wire logic [COUNT_WIDTH-1:0] cmp2_point [CCC_CHANNELS],
   input wire logic [COUNT_WIDTH-1:0] preset_value [CCC_CHANNELS],
   input wire logic [CCC_CHANNELS-1:0] preset_on_match_cfg,
   input wire logic [CCC_CHANNELS-1:0] zphase_preset_req_flag,
   // Program commands
   input wire logic [CCC_CHANNELS-1:0] cmp1_match_clear_cmd,
   input wire logic [CCC_CHANNELS-1:0] cmp2_match_clear_cmd,
   input wire logic [CCC_CHANNELS-1:0] match_output_enable_cmd,
   // Interrupt configuration, index = source
   input wire logic [CCC_SOURCES-1:0] irq_use_cfg,
   input wire logic [CCC_SOURCES-1:0] interrupt_mask_op,
   input wire logic [CCC_IRQ_NUM_WIDTH-1:0] irq_number_cfg [CCC_SOURCES],
   // Status flags, index = source
   output logic [CCC_SOURCES-1:0] greater_flag,
   output logic [CCC_SOURCES-1:0] match_flag,
   output logic [CCC_SOURCES-1:0] less_flag,
   // Preset load toward counter
   output logic [CCC_CHANNELS-1:0] preset_load,
   output logic [COUNT_WIDTH-1:0] preset_load_value [CCC_CHANNELS],
   // Output pins and interrupt requests
   output logic [CCC_SOURCES-1:0] match_output,
   output logic [CCC_SOURCES-1:0] irq_req,
   output logic [CCC_IRQ_NUM_WIDTH-1:0] irq_number [CCC_SOURCES]
);
   // Refuse parameter values that the logic cannot serve.
   generate
      if (COUNT_WIDTH < 1) begin : g_bad_width
         $error("ccc_compare: COUNT_WIDTH must be at least 1");
      end
      if (IRQ_LATENCY_CYCLES < 1) begin : g_bad_latency
         $error("ccc_compare: IRQ_LATENCY_CYCLES must be at least 1");
      end
      if (CCC_POINTS != 2) begin : g_bad_points
         $error("ccc_compare: each channel needs exactly two compare points");
      end
      if (CCC_SOURCES != CCC_CHANNELS * CCC_POINTS) begin : g_bad_sources
         $error("ccc_compare: one interrupt source per compare point is required");
      end
   endgenerate

   // Latency counter width, wide enough to hold the full count.
   localparam int LW = $clog2(IRQ_LATENCY_CYCLES + 1);

   // Per-source selection of count, point and commands.
   wire [COUNT_WIDTH-1:0] src_count_w [CCC_SOURCES];
   wire [COUNT_WIDTH-1:0] pt_w [CCC_SOURCES];
   wire [CCC_SOURCES-1:0] clear_w;
   wire [CCC_SOURCES-1:0] ch_enable_w;

   // Per-source compare results.
   wire [CCC_SOURCES-1:0] eq_w;
   wire [CCC_SOURCES-1:0] gt_w;
   wire [CCC_SOURCES-1:0] lt_w;

   // Per-source flag and pin next values.
   wire [CCC_SOURCES-1:0] flag_hold_w;
   wire [CCC_SOURCES-1:0] flag_d;
   wire [CCC_SOURCES-1:0] rise_w;
   wire [CCC_SOURCES-1:0] out_d;

   // Per-source interrupt latency path.
   wire [CCC_SOURCES-1:0] arm_w;
   wire [CCC_SOURCES-1:0] lat_at_end_w;
   wire [CCC_SOURCES-1:0] lat_done_w;
   wire [CCC_SOURCES-1:0] lat_restart_w;
   wire [CCC_SOURCES-1:0] pend_d;
   wire [CCC_SOURCES-1:0] irq_d;
   wire [LW-1:0] lat_next_w [CCC_SOURCES];
   wire [LW-1:0] lat_cnt_d [CCC_SOURCES];
   wire [CCC_IRQ_NUM_WIDTH-1:0] irq_number_d [CCC_SOURCES];

   // Per-channel preset path.
   wire [CCC_CHANNELS-1:0] cmp1_rise_w;
   wire [CCC_CHANNELS-1:0] preset_allow_w;
   wire [CCC_CHANNELS-1:0] load_w;
   wire [COUNT_WIDTH-1:0] preset_pick_w [CCC_CHANNELS];

   // State registers.
   logic [CCC_SOURCES-1:0] match_flag_q;
   logic [CCC_SOURCES-1:0] pend_q;
   logic [LW-1:0] lat_cnt_q [CCC_SOURCES];

   // One slice per compare point; the source index is channel times two plus point.
   genvar s;
   generate
      for (s = 0; s < CCC_SOURCES; s++) begin : g_src
         localparam int CH = s / CCC_POINTS;
         localparam bit P1 = (s % CCC_POINTS) == 0;

         assign src_count_w[s] = count_value[CH];
         assign pt_w[s] = P1 ? cmp1_point[CH] : cmp2_point[CH];
         assign clear_w[s] = P1 ? cmp1_match_clear_cmd[CH] : cmp2_match_clear_cmd[CH];
         // (R20) one enable per channel
         assign ch_enable_w[s] = match_output_enable_cmd[CH];

         // (R1) equality compare
         assign eq_w[s] = src_count_w[s] == pt_w[s];
         // (R21) magnitude compares
         assign gt_w[s] = src_count_w[s] > pt_w[s];
         assign lt_w[s] = src_count_w[s] < pt_w[s];

         // The clear command wins over a match in the same cycle.
         // Releasing the clear during a match sets the flag again.
         // (R6) (R22) clear holds flag off
         assign flag_hold_w[s] = match_flag_q[s] | eq_w[s];
         assign flag_d[s] = clear_w[s] ? 1'b0 : flag_hold_w[s];
         // (R19) rising edge only; the pin of (R4) follows the level of flag_d
         assign rise_w[s] = flag_d[s] & ~match_flag_q[s];
         // (R2) enable gates only the pin
         assign out_d[s] = flag_d[s] & ch_enable_w[s];

         // (R16) use setting arms request
         assign arm_w[s] = rise_w[s] & irq_use_cfg[s];
         // A new edge while a request is pending restarts the count.
         // The request therefore always follows the latest edge.
         // (R18) latency from match edge
         assign lat_at_end_w[s] = lat_cnt_q[s] == LW'(IRQ_LATENCY_CYCLES - 1);
         assign lat_done_w[s] = pend_q[s] & lat_at_end_w[s];
         assign lat_restart_w[s] = arm_w[s] | lat_done_w[s];
         assign pend_d[s] = arm_w[s] | (pend_q[s] & ~lat_done_w[s]);
         assign lat_next_w[s] = pend_q[s] ? lat_cnt_q[s] + 1'b1 : lat_cnt_q[s];
         assign lat_cnt_d[s] = lat_restart_w[s] ? '0 : lat_next_w[s];
         // (R17) mask gates request
         assign irq_d[s] = lat_done_w[s] & interrupt_mask_op[s];
         // (R14) (R15) configured source number
         assign irq_number_d[s] = irq_number_cfg[s];
      end
   endgenerate

   // One slice per channel; only point 1 of a channel can preset.
   genvar c;
   generate
      for (c = 0; c < CCC_CHANNELS; c++) begin : g_ch
         // (R8) only point 1 presets
         assign cmp1_rise_w[c] = rise_w[c * CCC_POINTS];
         // (R12) Z-phase request blocks preset
         assign preset_allow_w[c] = preset_on_match_cfg[c] & ~zphase_preset_req_flag[c];
         // (R7) (R11) load on point-1 edge
         assign load_w[c] = cmp1_rise_w[c] & preset_allow_w[c];
         // The value is taken at the edge itself, so a late write still lands.
         // (R10) newest preset value
         assign preset_pick_w[c] = preset_value[c];
      end
   endgenerate

   // Registered flags and outputs, one block per register.

   // Holds the latched flag that the edge detector compares against.
   // (R23) flag per update
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            match_flag_q[i] <= CCC_FLAG_RESET;
         end
      end else begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            match_flag_q[i] <= flag_d[i];
         end
      end
   end

   // Status copy of the latched flag for the program.
   // (R1) match status flag
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            match_flag[i] <= CCC_FLAG_RESET;
         end
      end else begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            match_flag[i] <= flag_d[i];
         end
      end
   end

   // Greater status follows the count on every update.
   // (R21) greater status flag
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            greater_flag[i] <= CCC_FLAG_RESET;
         end
      end else begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            greater_flag[i] <= gt_w[i];
         end
      end
   end

   // Less status is independent of the latched match flag.
   // (R3) compares may overlap
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            less_flag[i] <= CCC_FLAG_RESET;
         end
      end else begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            less_flag[i] <= lt_w[i];
         end
      end
   end

   // The pin turns on when the flag and channel enable are both set and stays until the clear or the enable drops.
   // (R4) (R20) gated output pin
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            match_output[i] <= CCC_FLAG_RESET;
         end
      end else begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            match_output[i] <= out_d[i];
         end
      end
   end

   // Marks a request that is waiting out its latency.
   // (R18) pending request
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            pend_q[i] <= CCC_FLAG_RESET;
         end
      end else begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            pend_q[i] <= pend_d[i];
         end
      end
   end

   // Counts clock cycles since the latest armed edge.
   // (R18) latency counter
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            lat_cnt_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            lat_cnt_q[i] <= lat_cnt_d[i];
         end
      end
   end

   // A single-cycle request per edge; a held flag raises no more.
   // (R19) one request per edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            irq_req[i] <= CCC_FLAG_RESET;
         end
      end else begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            irq_req[i] <= irq_d[i];
         end
      end
   end

   // Source numbers are reassignable while running.
   // (R15) source number register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            irq_number[i] <= CCC_IRQ_NUM_RESET;
         end
      end else begin
         for (int i = 0; i < CCC_SOURCES; i++) begin
            irq_number[i] <= irq_number_d[i];
         end
      end
   end

   // Tells the counter to take the preset value for one cycle.
   // (R9) preset load strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CCC_CHANNELS; i++) begin
            preset_load[i] <= CCC_FLAG_RESET;
         end
      end else begin
         for (int i = 0; i < CCC_CHANNELS; i++) begin
            preset_load[i] <= load_w[i];
         end
      end
   end

   // Carries the preset value sampled at the same edge as the strobe.
   // (R10) preset value at edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < CCC_CHANNELS; i++) begin
            preset_load_value[i] <= '0;
         end
      end else begin
         for (int i = 0; i < CCC_CHANNELS; i++) begin
            preset_load_value[i] <= preset_pick_w[i];
         end
      end
   end
endmodule
`default_nettype wire

// ===== ccc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ccc_chk
   import ccc_pkg::*;
#(parameter int COUNT_WIDTH = 8) (
   input wire logic core_clk, rst_n,
   input wire logic [COUNT_WIDTH-1:0] count_value [CCC_CHANNELS], cmp1_point [CCC_CHANNELS],
   input wire logic [1:0] preset_on_match_cfg, zphase_preset_req_flag, cmp1_match_clear_cmd,
   input wire logic [3:0] irq_use_cfg, interrupt_mask_op, match_flag, match_output, irq_req,
   input wire logic [1:0] preset_load);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_eq; count_value[0] == cmp1_point[0] && !cmp1_match_clear_cmd[0] |=> match_flag[0]; endproperty
   a_eq: assert property (p_eq) else $error("match flag missing");
   property p_clr; cmp1_match_clear_cmd[0] |=> !match_flag[0]; endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_out; (match_output & ~match_flag) == 4'h0; endproperty
   a_out: assert property (p_out) else $error("output without flag");
   property p_irq; $rose(match_flag[0]) && irq_use_cfg[0] && interrupt_mask_op[0] |-> ##4 irq_req[0]; endproperty
   a_irq: assert property (p_irq) else $error("interrupt late");
   property p_gate; (irq_req & ~(irq_use_cfg & interrupt_mask_op)) == 4'h0; endproperty
   a_gate: assert property (p_gate) else $error("interrupt not gated");
   property p_pulse; irq_req[0] |=> !irq_req[0]; endproperty
   a_pulse: assert property (p_pulse) else $error("interrupt repeated");
   property p_pre; $rose(match_flag[0]) |-> preset_load[0] == $past(preset_on_match_cfg[0] && !zphase_preset_req_flag[0]); endproperty
   a_pre: assert property (p_pre) else $error("preset load wrong");
   property p_p2; preset_load[0] |-> $rose(match_flag[0]); endproperty
   a_p2: assert property (p_p2) else $error("preset without edge");
endmodule
bind ccc_compare ccc_chk #(.COUNT_WIDTH(COUNT_WIDTH)) u_chk (.*);
`default_nettype wire

// ===== ccc_prog.sv
`timescale 1ns/1ps
`default_nettype none
module ccc_prog #(parameter int HOLD = 3) (
   input wire logic core_clk,
   input wire logic go,
   output logic clr);
   int n = 0;
   always @(posedge core_clk) n <= #1 (go ? HOLD : n - int'(n > 0));
   assign clr = n > 0;
endmodule
`default_nettype wire

// ===== ccc_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic core_clk = 0, rst_n = 0, go = 0, pclr;
   logic [7:0] cv[2], p1[2], p2[2], pv[2], plv[2];
   logic [1:0] pcfg = 0, zf = 0, en = 0, pl, c2clr = 0;
   logic [3:0] use_c = 4'hf, mask = 4'h7, gf, mf, lf, mo, irq;
   logic [7:0] inum_c[4] = '{8'h32, 8'h33, 8'h34, 8'h35}, inum[4];
   int n_errors = 0, tests_run = 0;
   always #2 core_clk = ~core_clk;
   ccc_prog prog (.core_clk(core_clk), .go(go), .clr(pclr));
   ccc_compare #(.COUNT_WIDTH(8), .IRQ_LATENCY_CYCLES(4)) DUT (.core_clk(core_clk), .rst_n(rst_n),
      .count_value(cv), .cmp1_point(p1), .cmp2_point(p2), .preset_value(pv),
      .preset_on_match_cfg(pcfg), .zphase_preset_req_flag(zf), .cmp1_match_clear_cmd({1'b0, pclr}),
      .cmp2_match_clear_cmd(c2clr), .match_output_enable_cmd(en), .irq_use_cfg(use_c),
      .interrupt_mask_op(mask), .irq_number_cfg(inum_c), .greater_flag(gf), .match_flag(mf),
      .less_flag(lf), .preset_load(pl), .preset_load_value(plv), .match_output(mo),
      .irq_req(irq), .irq_number(inum));
   task cyc(input int k); repeat (k) @(posedge core_clk); #1; endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end
   endtask
   task wrap_up;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("== PASSED =="); else $display("== FAILED ==");
      $finish;
   endtask
   task t_hit;
      cv = '{8'h05, 8'h03};
      cyc(1);
      chk(mf, 4'b1001);
      chk(gf, 4'h0);
      chk(lf, 4'b0110);
      chk(mo, 4'h0);
      chk(pl, 2'b01);
      chk(plv[0], 8'h40);
      en = 2'b11;
      cyc(1);
      chk(pl, 2'b00);
      cyc(1);
      chk(mo, 4'b1001);
      cyc(2);
      chk(irq, 4'b0001);
      chk(inum[3], 8'h35);
      cyc(1);
      chk(irq, 4'h0);
   endtask
   task t_clr;
      go = 1;
      zf = 2'b01;
      cyc(1);
      go = 0;
      cyc(1);
      chk(mf[0], 1'b0);
      cyc(3);
      chk(mf[0], 1'b1);
      chk(pl, 2'b00);
      cyc(4);
      chk(irq, 4'b0001);
      cv[1] = 8'h08;
      cyc(1);
      chk(gf, 4'b1100);
      chk(lf, 4'b0010);
   endtask
   initial begin #20000; n_errors++; wrap_up; end
   initial begin
      cv = '{8'h00, 8'h00}; p1 = '{8'h05, 8'h07}; p2 = '{8'h09, 8'h03}; pv = '{8'h11, 8'h22};
      repeat (8) @(posedge core_clk);
      #1 rst_n = 1;
      pcfg = 2'b11;
      pv[0] = 8'h40;
      cyc(2);
      t_hit;
      t_clr;
      wrap_up;
   end
endmodule
`default_nettype wire
